// [src/mbm_master.sv]
// bus master that polls and configures gas monitors over a half-duplex RTU link
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module mbm_master
   import mbm_pkg::*;
#(
   parameter int RESP_DIRECT = RESP_DIRECT_CYC,  // answer wait, direct
   parameter int RESP_RELAY  = RESP_RELAY_CYC,   // answer wait, relayed
   parameter int POLL_MIN    = POLL_MIN_CYC,     // least spacing of queries
   parameter int DEPTH       = 256               // frame memory bytes
) (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   input  wire logic [3:0]  addr,
   input  wire logic [15:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic      [15:0] rdata,
   input  wire logic        line_rx,
   output logic             line_tx,
   output logic             line_oe
);
   typedef enum logic [2:0] {MBM_IDLE, MBM_GAP, MBM_TX, MBM_WAIT, MBM_RX} mbm_state_t;

   mbm_state_t  state;          // transaction phase
   logic        relay;          // monitor reached through display
   logic        two_stop;       // two stop bits
   logic [15:0] baud_div;       // cycles per bit
   logic [7:0]  tx_len;         // query bytes before crc
   logic [7:0]  ptr;            // software memory pointer
   logic [7:0]  flags;          // status bits
   logic [7:0]  excode;         // last exception code
   logic [7:0]  rx_len;         // answer bytes
   logic [7:0]  q_node, q_fc;   // shadows of query header bytes
   logic [15:0] q_addr, q_val;  // shadows of query field words
   logic [31:0] poll_cnt;       // cycles since last query, saturating
   logic [31:0] resp_cnt;       // cycles waiting for answer
   logic [15:0] baud_cnt;       // free bit tick divider
   logic [5:0]  gap_cnt;        // silent bit times
   logic [10:0] tx_shift;       // outgoing character
   logic [3:0]  tx_cnt;         // bits still to show
   logic [7:0]  tx_idx;         // next byte of query
   logic [15:0] crc;            // running check, tx then rx
   logic [2:0]  rx_sync;        // pin synchroniser
   logic        rx_lvl, rx_lvl_d; // filtered level and its delay
   logic [15:0] rx_cnt;         // sample timer
   logic [3:0]  rx_bits;        // bits left in character
   logic [7:0]  rx_shift;       // incoming character
   logic        rd_data_q;        // memory read in flight
   logic [15:0] rd_reg;         // registered read value
   logic [7:0]  mem_dout;       // frame memory read data
   logic        node_bad;       // answer from a foreign node

   // decoding
   wire         is_wr_ctrl  = wr && addr == REG_CTRL;
   wire         is_wr_data  = wr && addr == REG_DATA && state == MBM_IDLE;
   wire         is_rd_data  = rd && addr == REG_DATA;
   wire         tick        = baud_cnt == 16'h0000;
   wire  [3:0]  char_bits   = two_stop ? BITS_TWO_STOP : BITS_ONE_STOP;
   wire  [31:0] resp_lim    = relay ? 32'(RESP_RELAY) : 32'(RESP_DIRECT);
   wire         in_std      = q_addr >= STD_REG_LO && q_addr <= STD_REG_HI;
   wire         fc_ok       = q_fc == FC_READ_HOLD || q_fc == FC_WRITE_SINGLE
                              || (q_fc == FC_PRESET_MULTI && !in_std);
   // the monitor does not range-check writes, so the master refuses a bad gas code
   wire         gas_bad     = q_fc == FC_WRITE_SINGLE && q_addr >= GAS_TYPE_LO
                              && q_addr <= GAS_TYPE_HI && q_val > GAS_CODE_MAX;
   wire         spaced      = poll_cnt == 32'(POLL_MIN);
   wire         go_req      = is_wr_ctrl && wdata[CTRL_GO] && state == MBM_IDLE;
   wire         go_ok       = go_req && spaced && fc_ok && !gas_bad
                              && q_node != 8'h00 && tx_len != 8'h00;
   wire         tx_done     = tx_idx == 8'(tx_len + 8'h02);
   wire  [7:0]  tx_byte     = tx_idx < tx_len ? mem_dout
                              : (tx_idx == tx_len ? crc[7:0] : crc[15:8]);
   wire         rx_active   = state == MBM_WAIT || state == MBM_RX;
   wire         rx_fire     = rx_bits != 4'h0 && rx_cnt == 16'h0000;
   wire         rx_byte     = rx_fire && rx_bits == 4'h1;
   wire         rx_start    = rx_active && rx_bits == 4'h0 && rx_lvl_d && !rx_lvl;
   wire  [7:0]  rx_data     = {rx_lvl, rx_shift[7:1]};
   wire         frame_end   = state == MBM_RX && gap_cnt == GAP_BITS;
   wire         crc_good    = crc == 16'h0000 && rx_len >= 8'h04;
   wire         timed_out   = state == MBM_WAIT && resp_cnt == resp_lim;
   wire  [7:0]  mem_waddr   = state == MBM_IDLE ? ptr : rx_len;
   wire  [7:0]  mem_raddr   = state == MBM_IDLE ? ptr : tx_idx;
   wire         mem_we      = is_wr_data || (rx_byte && state == MBM_RX) || (rx_byte && state == MBM_WAIT);

   mbm_frame_mem #(.W(8), .DEPTH(DEPTH), .AW(8)) u_mem (
      .clk_sys (clk_sys),
      .we      (mem_we && (state == MBM_IDLE || rx_len < 8'(DEPTH - 1))),
      .waddr   (mem_waddr),
      .wdata   (state == MBM_IDLE ? wdata[7:0] : rx_data),
      .raddr   (mem_raddr),
      .rdata   (mem_dout)
   );

   // line drivers: drive only while the query goes out
   assign line_oe = state == MBM_TX;
   assign line_tx = state == MBM_TX ? tx_shift[0] : 1'b1;

   // register reads answer one cycle later
   assign rdata = rd_data_q ? {8'h00, mem_dout} : rd_reg;

   // software configuration registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         relay    <= CTRL_RST[CTRL_RELAY];
         two_stop <= CTRL_RST[CTRL_TWO_STOP];
         baud_div <= BAUD_DIV_RST;
         tx_len   <= 8'h00;
      end else begin
         if (is_wr_ctrl) begin
            relay    <= wdata[CTRL_RELAY];
            two_stop <= wdata[CTRL_TWO_STOP];
         end
         if (wr && addr == REG_BAUD && state == MBM_IDLE) begin
            baud_div <= wdata;
         end
         if (wr && addr == REG_TXLEN && state == MBM_IDLE) begin
            tx_len <= wdata[7:0];
         end
      end
   end

   // pointer and header shadows, captured as software fills the query
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ptr    <= 8'h00;
         q_node <= 8'h00;
         q_fc   <= 8'h00;
         q_addr <= 16'h0000;
         q_val  <= 16'h0000;
      end else begin
         if (wr && addr == REG_PTR) begin
            ptr <= wdata[7:0];
         end else if (is_wr_data || (is_rd_data && state == MBM_IDLE)) begin
            ptr <= ptr + 8'h01;
         end
         // protocol fields travel high byte first
         if (is_wr_data) begin
            unique case (ptr)
               8'h00:   q_node        <= wdata[7:0];
               8'h01:   q_fc          <= wdata[7:0];
               8'h02:   q_addr[15:8]  <= wdata[7:0];
               8'h03:   q_addr[7:0]   <= wdata[7:0];
               8'h04:   q_val[15:8]   <= wdata[7:0];
               8'h05:   q_val[7:0]    <= wdata[7:0];
               default: q_node        <= q_node;
            endcase
         end
      end
   end

   // read data register
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_q <= 1'b0;
         rd_reg    <= 16'h0000;
      end else begin
         rd_data_q <= is_rd_data;
         unique case (addr)
            REG_CTRL:   rd_reg <= {13'h0000, two_stop, relay, 1'b0};
            REG_BAUD:   rd_reg <= baud_div;
            REG_TXLEN:  rd_reg <= {8'h00, tx_len};
            REG_STATUS: rd_reg <= {8'h00, flags[7:1], state != MBM_IDLE};
            REG_EXCODE: rd_reg <= {8'h00, excode};
            REG_PTR:    rd_reg <= {8'h00, ptr};
            REG_RXLEN:  rd_reg <= {8'h00, rx_len};
            default:    rd_reg <= 16'h0000;
         endcase
      end
   end

   // pin synchroniser; a change counts once the last two stages agree
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_sync  <= 3'h7;
         rx_lvl   <= 1'b1;
         rx_lvl_d <= 1'b1;
      end else begin
         rx_sync  <= {rx_sync[1:0], line_rx};
         if (rx_sync[1] == rx_sync[2]) begin
            rx_lvl <= rx_sync[2];
         end
         rx_lvl_d <= rx_lvl;
      end
   end

   // free bit tick and gap, spacing and answer counters
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         baud_cnt <= 16'h0000;
         gap_cnt  <= 6'h00;
         poll_cnt <= 32'(POLL_MIN);
         resp_cnt <= 32'h0000_0000;
      end else begin
         baud_cnt <= tick ? baud_div - 16'h0001 : baud_cnt - 16'h0001;
         // silence only counts while the line idles high
         if (rx_bits != 4'h0 || !rx_lvl || state == MBM_IDLE || state == MBM_TX) begin
            gap_cnt <= 6'h00;
         end else if (tick && gap_cnt != GAP_BITS) begin
            gap_cnt <= gap_cnt + 6'h01;
         end
         poll_cnt <= go_ok ? 32'h0000_0000 : (spaced ? poll_cnt : poll_cnt + 32'h1);
         resp_cnt <= state == MBM_WAIT ? resp_cnt + 32'h1 : 32'h0000_0000;
      end
   end

   // receiver: half-bit delay from start edge, then sample each bit centre
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rx_cnt   <= 16'h0000;
         rx_bits  <= 4'h0;
         rx_shift <= 8'h00;
      end else if (rx_start) begin
         rx_cnt  <= baud_div >> 1;
         rx_bits <= RX_BITS_START;
      end else if (rx_fire) begin
         rx_cnt <= baud_div - 16'h0001;
         if (rx_bits == RX_BITS_START && rx_lvl) begin
            rx_bits <= 4'h0;                    // glitch, not a start bit
         end else begin
            rx_bits  <= rx_bits - 4'h1;
            rx_shift <= {rx_lvl, rx_shift[7:1]};
         end
      end else if (rx_bits != 4'h0) begin
         rx_cnt <= rx_cnt - 16'h0001;
      end
   end

   // transaction sequencer
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state    <= MBM_IDLE;
         flags    <= 8'h00;
         excode   <= 8'h00;
         rx_len   <= 8'h00;
         tx_shift <= 11'h7FF;
         tx_cnt   <= 4'h0;
         tx_idx   <= 8'h00;
         crc      <= CRC_INIT;
         node_bad <= 1'b0;
      end else begin
         unique case (state)
            MBM_IDLE: begin
               if (go_ok) begin
                  flags    <= 8'h00;
                  excode   <= 8'h00;
                  rx_len   <= 8'h00;
                  tx_idx   <= 8'h00;
                  tx_cnt   <= 4'h0;
                  crc      <= CRC_INIT;
                  state    <= MBM_GAP;
               end else if (go_req) begin
                  flags[ST_REFUSED] <= 1'b1;
               end
            end
            MBM_GAP: begin
               // hold off until the line has been quiet for a frame gap
               if (gap_cnt == GAP_BITS) begin
                  state <= MBM_TX;
               end
            end
            MBM_TX: begin
               if (tick) begin
                  if (tx_cnt > 4'h1) begin
                     tx_shift <= {1'b1, tx_shift[10:1]};
                     tx_cnt   <= tx_cnt - 4'h1;
                  end else if (tx_done) begin
                     state    <= MBM_WAIT;
                     crc      <= CRC_INIT;
                     node_bad <= 1'b0;
                  end else begin
                     tx_shift <= {2'h3, tx_byte, 1'b0};
                     tx_cnt   <= char_bits;
                     tx_idx   <= tx_idx + 8'h01;
                     if (tx_idx < tx_len) begin
                        crc <= crc_step(crc, tx_byte);
                     end
                  end
               end
            end
            MBM_WAIT, MBM_RX: begin
               if (rx_byte) begin
                  state  <= MBM_RX;
                  rx_len <= rx_len + 8'h01;
                  crc    <= crc_step(crc, rx_data);
                  if (rx_len == 8'h00 && rx_data != q_node) begin
                     node_bad <= 1'b1;
                  end
                  if (rx_len == 8'h02) begin
                     excode <= rx_data;
                  end
                  if (rx_len == 8'h01) begin
                     flags[ST_EXC] <= rx_data[7];
                  end
               end else if (frame_end && node_bad) begin
                  // foreign answer: drop it and keep waiting
                  state    <= MBM_WAIT;
                  rx_len   <= 8'h00;
                  crc      <= CRC_INIT;
                  node_bad <= 1'b0;
                  flags[ST_EXC] <= 1'b0;
               end else if (frame_end) begin
                  state             <= MBM_IDLE;
                  flags[ST_DONE]    <= 1'b1;
                  flags[ST_CRC_ERR] <= !crc_good;
                  flags[ST_VALID]   <= crc_good && !flags[ST_EXC];
                  flags[ST_EXC]     <= crc_good && flags[ST_EXC];
                  flags[ST_DEV_BUSY] <= crc_good && flags[ST_EXC] && excode == EXC_BUSY;
               end else if (timed_out) begin
                  state              <= MBM_IDLE;
                  flags[ST_DONE]     <= 1'b1;
                  flags[ST_TIMEOUT]  <= 1'b1;
               end
            end
         endcase
      end
   end

   // checks
   sequence s_query_go;
      go_ok;
   endsequence
   sequence s_quiet_gap;
      !line_oe && line_tx;
   endsequence
   a_line_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $fell(line_oe) |-> $past(line_tx) && state == MBM_WAIT) else $error("line released before stop bit");
   a_poll_spacing: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_query_go |=> poll_cnt == 32'h0 ##1 !go_ok) else $error("query spacing not restarted");
   a_gap_before_tx: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_query_go |=> s_quiet_gap [*2]) else $error("line taken without gap");
   a_start_bit_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state == MBM_TX && tick && tx_cnt <= 4'h1 && !tx_done |=> !line_tx && tx_cnt == char_bits)
      else $error("character not opened by start bit");
   a_crc_verdict: assert property (@(posedge clk_sys) disable iff (!rst_n)
      frame_end && !node_bad |=> flags[ST_CRC_ERR] == ($past(crc) != 16'h0000 || $past(rx_len) < 8'h04))
      else $error("crc verdict wrong");
   a_valid_needs_crc: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(flags[ST_VALID]) |-> !flags[ST_CRC_ERR] && !flags[ST_TIMEOUT]) else $error("bad data marked valid");
   a_timeout_limit: assert property (@(posedge clk_sys) disable iff (!rst_n)
      state == MBM_WAIT |-> resp_cnt <= resp_lim) else $error("answer wait overran");
   a_fc_filter: assert property (@(posedge clk_sys) disable iff (!rst_n)
      go_req && !fc_ok |=> flags[ST_REFUSED] && state == MBM_IDLE) else $error("illegal function sent");
   a_gas_range: assert property (@(posedge clk_sys) disable iff (!rst_n)
      go_req && gas_bad |=> state == MBM_IDLE) else $error("gas code out of range sent");
   a_foreign_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
      frame_end && node_bad |=> state == MBM_WAIT && rx_len == 8'h00) else $error("foreign answer kept");
endmodule
`default_nettype wire

// [common/mbm_pkg.sv]
// constants shared by the gas monitor bus master and its bench
package mbm_pkg;
   // clock and link timing
   localparam int          CLK_HZ          = 10_000_000;             // clk_sys rate
   localparam int          BAUD_DEFAULT    = 19_200;                 // link rate after reset
   localparam logic [15:0] BAUD_DIV_RST    = 16'(CLK_HZ / BAUD_DEFAULT); // cycles per bit
   localparam int          RESP_DIRECT_MS  = 4000;                   // answer limit, monitor on bus
   localparam int          RESP_RELAY_MS   = 8000;                   // answer limit, through display
   localparam int          POLL_MIN_MS     = 500;                    // least spacing of queries
   localparam int          CYC_PER_MS      = CLK_HZ / 1000;          // cycles in one millisecond
   localparam int          RESP_DIRECT_CYC = RESP_DIRECT_MS * CYC_PER_MS;
   localparam int          RESP_RELAY_CYC  = RESP_RELAY_MS * CYC_PER_MS;
   localparam int          POLL_MIN_CYC    = POLL_MIN_MS * CYC_PER_MS;
   localparam logic [5:0]  GAP_BITS        = 6'((7 * 11 + 1) / 2);   // 3.5 characters, rounded up
   localparam logic [3:0]  BITS_ONE_STOP   = 4'hA;                   // start, 8 data, 1 stop
   localparam logic [3:0]  BITS_TWO_STOP   = 4'hB;                   // start, 8 data, 2 stops
   localparam logic [3:0]  RX_BITS_START   = 4'h9;                   // start bit plus 8 data bits
   // software register offsets
   localparam logic [3:0]  REG_CTRL        = 4'h0;  // b0 go, b1 via display, b2 two stop bits
   localparam logic [3:0]  REG_BAUD        = 4'h1;  // cycles per bit
   localparam logic [3:0]  REG_TXLEN       = 4'h2;  // query length without crc
   localparam logic [3:0]  REG_STATUS      = 4'h3;  // flags, see bit positions
   localparam logic [3:0]  REG_EXCODE      = 4'h4;  // exception code of last answer
   localparam logic [3:0]  REG_PTR         = 4'h5;  // frame memory pointer
   localparam logic [3:0]  REG_DATA        = 4'h6;  // frame memory byte, pointer steps on access while idle
   localparam logic [3:0]  REG_RXLEN       = 4'h7;  // answer length including crc
   localparam int          CTRL_GO         = 0;
   localparam int          CTRL_RELAY      = 1;
   localparam int          CTRL_TWO_STOP   = 2;
   localparam logic [15:0] CTRL_RST        = 16'h0000;
   // status bit positions
   localparam int ST_BUSY = 0, ST_DONE = 1, ST_CRC_ERR = 2, ST_TIMEOUT = 3;
   localparam int ST_EXC  = 4, ST_REFUSED = 5, ST_DEV_BUSY = 6, ST_VALID = 7;
   // protocol codes
   localparam logic [7:0]  FC_READ_HOLD    = 8'h03;
   localparam logic [7:0]  FC_WRITE_SINGLE = 8'h06;
   localparam logic [7:0]  FC_PRESET_MULTI = 8'h10;
   localparam logic [7:0]  EXC_BUSY        = 8'h06;
   localparam logic [15:0] STD_REG_LO      = 16'd2000;  // standard groups, not block structures
   localparam logic [15:0] STD_REG_HI      = 16'd3999;
   localparam logic [15:0] GAS_TYPE_LO     = 16'd3000;  // per-zone gas type registers
   localparam logic [15:0] GAS_TYPE_HI     = 16'd3015;
   localparam logic [15:0] GAS_CODE_MAX    = 16'd65;
   localparam logic [15:0] CRC_INIT        = 16'hFFFF;
   localparam logic [15:0] CRC_POLY        = 16'hA001;

   // one byte of the reflected 16-bit frame check
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction
endpackage

// [src/mbm_frame_mem.sv]
// byte memory holding the outgoing query and then the incoming answer
`timescale 1ns/1ns
`default_nettype none
module mbm_frame_mem #(
   parameter int W     = 8,     // word width
   parameter int DEPTH = 256,   // words
   parameter int AW    = 8      // address width
) (
   input  wire logic          clk_sys,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [W-1:0]  wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [W-1:0]  rdata
);
   logic [W-1:0] mem [DEPTH];   // storage, no reset needed

   // write port and registered read port
   always_ff @(posedge clk_sys) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule
`default_nettype wire

// [testbench/mbm_mon_model.sv]
// gas monitor model: checks each query, answers queries to its node
`timescale 1ns/1ns
`default_nettype none
module mbm_mon_model #(
   parameter int         DIV  = 10,     // cycles per bit
   parameter logic [7:0] NODE = 8'h05   // own node id
) (
   input  wire logic clk_sys,
   input  wire logic line_tx,
   input  wire logic line_oe,
   output logic      line_rx
);
   logic [7:0]  q[$], r[$], b;   // query, answer, byte
   logic [15:0] c;               // frame check
   function automatic logic [15:0] fcs(input logic [7:0] m[$]);
      logic [15:0] s;
      s = 16'hFFFF;
      foreach (m[k]) begin
         s = s ^ {8'h00, m[k]};
         repeat (8) s = s[0] ? ((s >> 1) ^ 16'hA001) : (s >> 1);
      end
      return s;
   endfunction
   // slave only: speaks after a query, idle line held high by bias
   initial begin
      line_rx = 1'b1;
      forever begin
         q = {};
         @(posedge (line_oe & ~line_tx));
         while (line_oe) begin
            if (!line_tx) begin
               repeat (DIV * 3 / 2) @(posedge clk_sys);
               for (int i = 0; i < 8; i++) begin
                  b[i] = line_tx; // lsb first
                  repeat (DIV) @(posedge clk_sys);
               end
               q.push_back(b);
            end else @(posedge clk_sys);
         end
         // other nodes and bad check are ignored
         if (q.size() > 3 && q[0] == NODE && fcs(q) == 16'h0000) begin
            // one reading, unchanged between polls; low byte first
            r = {q[0], q[1], 8'h02, 8'h34, 8'h12};
            if (q[1] == 8'h10) r = {q[0], q[1], q[2], q[3], q[4], q[5]}; // stored to flash
            if ({q[2], q[3]} < 16'd1000) r = {q[0], q[1] | 8'h80, 8'h02}; // unknown address
            if ({q[2], q[3]} == 16'd2998) r = {q[0], q[1] | 8'h80, 8'h06}; // display on setup screen
            if ({q[2], q[3]} == 16'd2999) r[0] = ~NODE; // answer of a stranger
            c = fcs(r);
            if ({q[2], q[3]} == 16'd2997) c = c ^ 16'h0001; // damaged check
            r.push_back(c[7:0]);
            r.push_back(c[15:8]);
            repeat (40 * DIV) @(posedge clk_sys); // silence before answer
            foreach (r[k]) for (int i = 0; i < 10; i++) begin
               line_rx <= 1'(({1'b1, r[k], 1'b0}) >> i); // one stop bit
               repeat (DIV) @(posedge clk_sys);
            end
         end
      end
   end
endmodule
`default_nettype wire

// [testbench/modbus_rtu_slave_gas_monitor_bench.sv]
// self-checking bench for the rtu bus master
`timescale 1ns/1ns
`default_nettype none
module modbus_rtu_slave_gas_monitor_bench
   import mbm_pkg::*;
;
   logic        clk_sys = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [3:0]  addr    = 4'h0;
   logic [15:0] wdata   = 16'h0000, rdata, v;
   logic        line_tx, line_oe, line_rx;
   int          err_count = 0, samples_checked = 0;
   always #50 clk_sys = ~clk_sys;
   // short waits keep the run small
   mbm_master #(.RESP_DIRECT(6000), .RESP_RELAY(12000), .POLL_MIN(8000)) dut (.clk_sys(clk_sys),
      .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .line_rx(line_rx), .line_tx(line_tx), .line_oe(line_oe));
   mbm_mon_model #(.DIV(10)) mon (.clk_sys(clk_sys), .line_tx(line_tx), .line_oe(line_oe), .line_rx(line_rx));
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask
   // frame memory read data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      @(negedge clk_sys);
      v = rdata;
   endtask
   // fill and launch one query with control word c; v ends as the status just after the go
   task automatic go_q(input logic [7:0] n, input logic [7:0] f, input logic [15:0] a, input logic [15:0] d,
                       input logic [15:0] c);
      logic [7:0] m[6];
      m = '{n, f, a[15:8], a[7:0], d[15:8], d[7:0]}; // fields high byte first
      wr_reg(REG_PTR, 16'h0000);
      foreach (m[i]) wr_reg(REG_DATA, {8'h00, m[i]});
      wr_reg(REG_TXLEN, 16'h0006);
      wr_reg(REG_CTRL, c);
      rd_reg(REG_STATUS);
   endtask
   // one read query, then poll until idle; v ends as status
   task automatic txn(input logic [7:0] n, input logic [15:0] a, input logic [15:0] c);
      go_q(n, FC_READ_HOLD, a, 16'h0001, c);
      for (int k = 0; k < 5000 && v[ST_BUSY] !== 1'b0; k++) rd_reg(REG_STATUS);
   endtask
   task automatic t_reset;
      chk("oe idle", 16'h0000, {15'h0, line_oe});
      rd_reg(REG_BAUD);
      chk("baud", BAUD_DIV_RST, v);
      rd_reg(4'hF);
      chk("unmapped", 16'h0000, v);
      wr_reg(REG_BAUD, 16'd10);
   endtask
   task automatic t_read;
      txn(8'h05, 16'd2000, 16'h0001);
      chk("valid", 16'h0001, {15'h0, v[ST_VALID]});
      rd_reg(REG_RXLEN);
      chk("rxlen", 16'd7, v);
      wr_reg(REG_PTR, 16'h0000);
      repeat (4) rd_reg(REG_DATA);
      chk("low byte", 16'h0034, {8'h00, v[7:0]});
      wr_reg(REG_CTRL, 16'h0001);
      rd_reg(REG_STATUS);
      chk("refused", 16'h0001, {15'h0, v[ST_REFUSED]});
   endtask
   task automatic t_exc;
      repeat (8100) @(posedge clk_sys);
      txn(8'h05, 16'h0001, 16'h0001);
      chk("exception", 16'h0001, {15'h0, v[ST_EXC]});
      rd_reg(REG_EXCODE);
      chk("excode", 16'h0002, v);
   endtask
   task automatic t_silent;
      repeat (8100) @(posedge clk_sys);
      txn(8'h09, 16'd2000, 16'h0001);
      chk("timeout", 16'h0001, {15'h0, v[ST_TIMEOUT]});
      chk("oe released", 16'h0000, {15'h0, line_oe});
   endtask
   // spacing is met here, so only the filters can refuse; status keeps done and timeout
   task automatic t_refuse;
      repeat (8100) @(posedge clk_sys);
      go_q(8'h05, FC_PRESET_MULTI, 16'd2000, 16'h0001, 16'h0001);
      chk("preset std", 16'h002A, v);
      go_q(8'h05, FC_WRITE_SINGLE, 16'd3000, 16'h0042, 16'h0001);
      chk("gas code", 16'h002A, v);
   endtask
   // relayed, two stop bits; refusals above did not restart the spacing
   task automatic t_busy;
      txn(8'h05, 16'd2998, 16'h0007);
      chk("dev busy", 16'h0052, v);
   endtask
   task automatic t_crc;
      repeat (8100) @(posedge clk_sys);
      txn(8'h05, 16'd2997, 16'h0001);
      chk("crc err", 16'h0006, v);
   endtask
   // a stranger's answer is dropped and the wait runs out
   task automatic t_foreign;
      repeat (8100) @(posedge clk_sys);
      txn(8'h05, 16'd2999, 16'h0001);
      chk("foreign", 16'h000A, v);
   endtask
   task automatic stop_test;
      $display("mismatches %0d checks %0d", err_count, samples_checked);
      if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (80000) @(posedge clk_sys);
      err_count++;
      stop_test();
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      t_reset();
      t_read();
      t_exc();
      t_silent();
      t_refuse();
      t_busy();
      t_crc();
      t_foreign();
      stop_test();
   end
endmodule
`default_nettype wire
